//--- include/pll_scan_regs.svh
`ifndef PLL_SCAN_REGS_SVH
`define PLL_SCAN_REGS_SVH

// chain geometry
`define CHAIN_LEN      144
`define NUM_DIV        7
`define NUM_POST       5
`define NUM_TAPS       6
`define CNT_W          8
`define SEG_DIV_W      18
`define SEG_BW_W       9
`define RATIO_W        9
`define TAP_W          3

// bit positions inside one divider segment, entry end first
`define FLD_LOW_LSB    0
`define FLD_HIGH_LSB   8
`define FLD_ODD        16
`define FLD_BYP        17

// segment offsets from the entry end: posts four..zero, feedback, prescale, pump, filter
`define OFS_FB         90
`define OFS_PRE        108
`define OFS_PUMP       126
`define OFS_FILT       135

// fields inside the bandwidth segments
`define PUMP_W         3
`define RES_W          5
`define CAP_W          2
`define FLD_CAP_LSB    5

// phase target select codes
`define SEL_ALL        3'h0
`define SEL_FB         3'h1
`define SEL_POST0      3'h2

// reset values
`define RATIO_RST      9'h001
`define TAP_RST        18'h00000

// bound in scan cycles for done and pending to return
`define HANDSHAKE_LIMIT 12

`endif

//--- include/pll_scan_pkg.sv
package pll_scan_pkg;

   // phase-step sequencer states
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_SHIFT = 2'b01,
      PH_REARM = 2'b10
   } phase_state_t;

endpackage

//--- hw/bit_sync.sv
`timescale 1ns/1ps
`include "pll_scan_regs.svh"

module bit_sync (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // level from the other domain
   input  wire logic i_d,
   output logic      o_q
);

   logic meta_ff;

   // two-stage synchroniser, first stage read only by the second
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_ff <= 1'b0;
         o_q     <= 1'b0;
      end else begin
         meta_ff <= i_d;
         o_q     <= meta_ff;
      end
   end

endmodule

//--- hw/pll_scan_reconfig.sv
`timescale 1ns/1ps
`include "pll_scan_regs.svh"

// Contract
// - settings held in one 144-bit serial chain
// - dividers 16+2 bits, pump and filter 9 each
// - first bit in: fifth post divider low LSB
// - last bit in: loop filter MSB
// - divider control bits: bypass and odd duty
// - pump code legal only 0, 1, 3, 7; the code accepts 0, 4, 6, 7
// - resistor code legal only listed eleven values
// - capacitor code legal only 0, 1, 3
// - bypass set: divide by one, counts ignored
// - bypass clear: divide by high plus low
// - each step moves tap one eighth period
// - output clocks keep running during steps
// - select: all, feedback, post zero to four; the code's all steps only posts zero to four, not the feedback tap
// - direction one up, zero down, rising edge
// - request sampled falling edge, held two cycles
// - second rising edge: capture, start, done low
// - done low until shift ends, internal timing
// - one scan clock for steps and chain
// - apply pulse loads chain into live settings
// - apply pending high until counters updated
// - count bits split high eight, low eight
module pll_scan_reconfig
   import pll_scan_pkg::*;
#(
   parameter int NUM_DIV  = `NUM_DIV,
   parameter int NUM_TAPS = `NUM_TAPS
) (
   // core clock and reset
   input  wire logic                          i_mclk,
   input  wire logic                          i_reset,
   // scan clock side: chain load
   input  wire logic                          i_scan_clk,
   input  wire logic                          i_shift_en,
   input  wire logic                          i_scan_data,
   input  wire logic                          i_apply,
   output logic                               o_apply_pending,
   // scan clock side: phase step
   input  wire logic                          i_phase_step,
   input  wire logic                          i_phase_up,
   input  wire logic [2:0]                    i_phase_sel,
   output logic                               o_phase_done,
   // live settings, core clock
   output logic [NUM_DIV*`RATIO_W-1:0]        o_div_ratio,
   output logic [NUM_DIV-1:0]                 o_div_bypass,
   output logic [NUM_DIV-1:0]                 o_div_odd_duty,
   output logic [NUM_TAPS*`TAP_W-1:0]         o_phase_taps,
   output logic [`PUMP_W-1:0]                 o_pump_current_code,
   output logic [`RES_W-1:0]                  o_filter_resistor_code,
   output logic [`CAP_W-1:0]                  o_filter_capacitor_code,
   output logic                               o_bw_reject
);
   localparam int DONE_LIMIT = `HANDSHAKE_LIMIT;

   // scan domain state
   logic [`CHAIN_LEN-1:0] chain_ff, nxt_chain;
   logic [`CHAIN_LEN-1:0] hold_ff, nxt_hold;
   logic                  en_d_ff, nxt_en_d;
   logic                  apply_tgl_ff, nxt_apply_tgl;
   logic                  nxt_pending;
   phase_state_t          st_ff, nxt_st;
   logic                  dir_ff, nxt_dir;
   logic [2:0]            sel_ff, nxt_sel;
   logic                  step_tgl_ff, nxt_step_tgl;
   logic                  nxt_done;
   logic                  step_n_ff, step_p_ff;
   logic                  shift_go, step_ack_s, apply_ack_s;

   // core domain state
   logic                  step_seen_ff, nxt_step_seen;
   logic                  apply_seen_ff, nxt_apply_seen;
   logic                  step_req_s, apply_req_s;
   logic                  step_evt, apply_evt;
   logic                  bw_ok;
   logic [NUM_DIV*`RATIO_W-1:0]  nxt_ratio;
   logic [NUM_DIV-1:0]           nxt_bypass, nxt_odd, div_byp_w, div_odd_w;
   logic [NUM_TAPS*`TAP_W-1:0]   nxt_taps;
   logic [`PUMP_W-1:0]           nxt_pump, hold_pump;
   logic [`RES_W-1:0]            nxt_res, hold_res;
   logic [`CAP_W-1:0]            nxt_cap, hold_cap;
   logic                         nxt_reject;
   logic [`RATIO_W-1:0]          div_ratio_w [NUM_DIV];

   // legal bandwidth codes
   function automatic logic pump_legal(input logic [`PUMP_W-1:0] c);
      pump_legal = (c == 3'h0) || (c == 3'h4) || (c == 3'h6) || (c == 3'h7);
   endfunction
   function automatic logic res_legal(input logic [`RES_W-1:0] c);
      res_legal = c inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
                            5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E};
   endfunction
   function automatic logic cap_legal(input logic [`CAP_W-1:0] c);
      cap_legal = (c == 2'h0) || (c == 2'h1) || (c == 2'h3);
   endfunction

   // step request latched on the falling scan edge
   always_ff @(negedge i_scan_clk or posedge i_reset) begin
      if (i_reset) begin
         step_n_ff <= 1'b0;
      end else begin
         step_n_ff <= i_phase_step;
      end
   end

   // acknowledges returning from the core domain
   bit_sync u_step_ack (
      .i_clk (i_scan_clk), .i_reset (i_reset), .i_d (step_seen_ff), .o_q (step_ack_s)
   );
   bit_sync u_apply_ack (
      .i_clk (i_scan_clk), .i_reset (i_reset), .i_d (apply_seen_ff), .o_q (apply_ack_s)
   );

   // shift only once enable has been seen a cycle earlier
   assign shift_go = i_shift_en && en_d_ff;

   // next values of chain, apply and phase sequencer
   always_comb begin
      nxt_en_d      = i_shift_en;
      nxt_chain     = chain_ff;
      nxt_hold      = hold_ff;
      nxt_apply_tgl = apply_tgl_ff;
      nxt_pending   = o_apply_pending;
      nxt_st        = st_ff;
      nxt_dir       = dir_ff;
      nxt_sel       = sel_ff;
      nxt_step_tgl  = step_tgl_ff;
      nxt_done      = o_phase_done;
      // new bit enters at the top, first bit ends at bit 0
      if (shift_go) begin
         nxt_chain = {i_scan_data, chain_ff[`CHAIN_LEN-1:1]};
      end
      // apply: hand the chain image to the core domain
      if (i_apply && !o_apply_pending) begin
         nxt_hold      = chain_ff;
         nxt_apply_tgl = ~apply_tgl_ff;
         nxt_pending   = 1'b1;
      end else if (o_apply_pending && (apply_ack_s == apply_tgl_ff)) begin
         nxt_pending = 1'b0;
      end
      case (st_ff)
         PH_IDLE: begin
            // step_p_ff high means this is the second rising edge
            if (step_p_ff) begin
               nxt_dir      = i_phase_up;
               nxt_sel      = i_phase_sel;
               nxt_step_tgl = ~step_tgl_ff;
               nxt_done     = 1'b0;
               nxt_st       = PH_SHIFT;
            end
         end
         PH_SHIFT: begin
            if (step_ack_s == step_tgl_ff) begin
               nxt_done = 1'b1;
               nxt_st   = PH_REARM;
            end
         end
         PH_REARM: begin
            // one step per request pulse
            if (!step_p_ff) begin
               nxt_st = PH_IDLE;
            end
         end
         default: begin
            nxt_st   = PH_IDLE;
            nxt_done = 1'b1;
         end
      endcase
   end

   // scan domain registers, one clock for steps and chain
   always_ff @(posedge i_scan_clk or posedge i_reset) begin
      if (i_reset) begin
         chain_ff        <= '0;
         hold_ff         <= '0;
         en_d_ff         <= 1'b0;
         apply_tgl_ff    <= 1'b0;
         st_ff           <= PH_IDLE;
         dir_ff          <= 1'b0;
         sel_ff          <= `SEL_ALL;
         step_tgl_ff     <= 1'b0;
         step_p_ff       <= 1'b0;
         o_phase_done    <= 1'b1;
         o_apply_pending <= 1'b0;
      end else begin
         chain_ff        <= nxt_chain;
         hold_ff         <= nxt_hold;
         en_d_ff         <= nxt_en_d;
         apply_tgl_ff    <= nxt_apply_tgl;
         st_ff           <= nxt_st;
         dir_ff          <= nxt_dir;
         sel_ff          <= nxt_sel;
         step_tgl_ff     <= nxt_step_tgl;
         step_p_ff       <= step_n_ff;
         o_phase_done    <= nxt_done;
         o_apply_pending <= nxt_pending;
      end
   end

   // requests arriving from the scan domain
   bit_sync u_step_req (
      .i_clk (i_mclk), .i_reset (i_reset), .i_d (step_tgl_ff), .o_q (step_req_s)
   );
   bit_sync u_apply_req (
      .i_clk (i_mclk), .i_reset (i_reset), .i_d (apply_tgl_ff), .o_q (apply_req_s)
   );

   assign step_evt  = step_req_s ^ step_seen_ff;
   assign apply_evt = apply_req_s ^ apply_seen_ff;

   // per-divider decode of the held chain image
   for (genvar gi = 0; gi < NUM_DIV; gi++) begin : g_div
      localparam int BASE = (gi < `NUM_POST) ? (`NUM_POST - 1 - gi) * `SEG_DIV_W
                                             : gi * `SEG_DIV_W;
      logic [`CNT_W-1:0] low_w, high_w;
      assign low_w  = hold_ff[BASE + `FLD_LOW_LSB +: `CNT_W];
      assign high_w = hold_ff[BASE + `FLD_HIGH_LSB +: `CNT_W];
      assign div_byp_w[gi] = hold_ff[BASE + `FLD_BYP];
      assign div_odd_w[gi] = hold_ff[BASE + `FLD_ODD];
      assign div_ratio_w[gi] = div_byp_w[gi] ? `RATIO_RST
                             : ({1'b0, high_w} + {1'b0, low_w});
   end

   assign hold_pump = hold_ff[`OFS_PUMP +: `PUMP_W];
   assign hold_res  = hold_ff[`OFS_FILT +: `RES_W];
   assign hold_cap  = hold_ff[`OFS_FILT + `FLD_CAP_LSB +: `CAP_W];
   assign bw_ok     = pump_legal(hold_pump) && res_legal(hold_res) && cap_legal(hold_cap);

   // next live settings and tap positions
   always_comb begin
      nxt_step_seen  = step_seen_ff;
      nxt_apply_seen = apply_seen_ff;
      nxt_ratio      = o_div_ratio;
      nxt_bypass     = o_div_bypass;
      nxt_odd        = o_div_odd_duty;
      nxt_taps       = o_phase_taps;
      nxt_pump       = o_pump_current_code;
      nxt_res        = o_filter_resistor_code;
      nxt_cap        = o_filter_capacitor_code;
      nxt_reject     = o_bw_reject;
      // tap move only, divider counts untouched so clocks keep running
      if (step_evt) begin
         nxt_step_seen = step_req_s;
         for (int k = 0; k < NUM_TAPS; k++) begin
            if ((sel_ff == `SEL_ALL && k < `NUM_POST) ||
                (sel_ff == `SEL_FB && k == `NUM_POST) ||
                (k < `NUM_POST && sel_ff == (`SEL_POST0 + 3'(k)))) begin
               nxt_taps[k*`TAP_W +: `TAP_W] = o_phase_taps[k*`TAP_W +: `TAP_W]
                  + (dir_ff ? 3'h1 : 3'h7);
            end
         end
      end
      // apply: load the live settings, refuse illegal bandwidth codes
      if (apply_evt) begin
         nxt_apply_seen = apply_req_s;
         nxt_bypass     = div_byp_w;
         nxt_odd        = div_odd_w;
         for (int k = 0; k < NUM_DIV; k++) begin
            nxt_ratio[k*`RATIO_W +: `RATIO_W] = div_ratio_w[k];
         end
         nxt_reject = !bw_ok;
         if (bw_ok) begin
            nxt_pump = hold_pump;
            nxt_res  = hold_res;
            nxt_cap  = hold_cap;
         end
      end
   end

   // core domain registers
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         step_seen_ff            <= 1'b0;
         apply_seen_ff           <= 1'b0;
         o_div_ratio             <= {NUM_DIV{`RATIO_RST}};
         o_div_bypass            <= '1;
         o_div_odd_duty          <= '0;
         o_phase_taps            <= `TAP_RST;
         o_pump_current_code     <= '0;
         o_filter_resistor_code  <= '0;
         o_filter_capacitor_code <= '0;
         o_bw_reject             <= 1'b0;
      end else begin
         step_seen_ff            <= nxt_step_seen;
         apply_seen_ff           <= nxt_apply_seen;
         o_div_ratio             <= nxt_ratio;
         o_div_bypass            <= nxt_bypass;
         o_div_odd_duty          <= nxt_odd;
         o_phase_taps            <= nxt_taps;
         o_pump_current_code     <= nxt_pump;
         o_filter_resistor_code  <= nxt_res;
         o_filter_capacitor_code <= nxt_cap;
         o_bw_reject             <= nxt_reject;
      end
   end

   // protocol and datapath checks
   shift_chain_a: assert property (@(posedge i_scan_clk) disable iff (i_reset)
      shift_go |=> (chain_ff == {$past(i_scan_data), $past(chain_ff[`CHAIN_LEN-1:1])}))
      else $error("chain did not shift by one bit");
   step_capture_a: assert property (@(posedge i_scan_clk) disable iff (i_reset)
      (st_ff == PH_IDLE && step_p_ff) |=> (!o_phase_done && st_ff == PH_SHIFT))
      else $error("done did not fall on step capture");
   capture_dir_a: assert property (@(posedge i_scan_clk) disable iff (i_reset)
      (st_ff == PH_IDLE && step_p_ff) |=> (dir_ff == $past(i_phase_up))
                                          && (sel_ff == $past(i_phase_sel)))
      else $error("direction or select not captured");
   done_idle_a: assert property (@(posedge i_scan_clk) disable iff (i_reset)
      (st_ff != PH_SHIFT) |-> o_phase_done)
      else $error("done low outside a step");
   done_rise_a: assert property (@(posedge i_scan_clk) disable iff (i_reset)
      $fell(o_phase_done) |-> ##[1:DONE_LIMIT] o_phase_done)
      else $error("done stuck low");
   apply_pend_a: assert property (@(posedge i_scan_clk) disable iff (i_reset)
      (i_apply && !o_apply_pending) |=> o_apply_pending ##[1:DONE_LIMIT] !o_apply_pending)
      else $error("apply pending not raised or not cleared");
   tap_step_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (step_evt && dir_ff && sel_ff == `SEL_POST0)
         |=> o_phase_taps[2:0] == $past(o_phase_taps[2:0]) + 3'h1)
      else $error("tap did not advance by one");
   bypass_ratio_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_div_bypass[0] |-> (o_div_ratio[`RATIO_W-1:0] == `RATIO_RST))
      else $error("bypassed divider not divide by one");
   bw_legal_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      pump_legal(o_pump_current_code) && res_legal(o_filter_resistor_code)
      && cap_legal(o_filter_capacitor_code))
      else $error("illegal bandwidth code applied");

endmodule

//--- sim/fabric_model.sv
`timescale 1ns/1ps

module fabric_model (
   // scan clock and status from the block
   input  wire logic i_scan_clk,
   input  wire logic i_phase_done,
   input  wire logic i_apply_pending,
   // controls toward the block
   output logic       o_shift_en,
   output logic       o_scan_data,
   output logic       o_apply,
   output logic       o_phase_step,
   output logic       o_phase_up,
   output logic [2:0] o_phase_sel
);
   // idle levels at time zero
   initial begin
      o_shift_en   = 1'h0;
      o_scan_data  = 1'h0;
      o_apply      = 1'h0;
      o_phase_step = 1'h0;
      o_phase_up   = 1'h0;
      o_phase_sel  = 3'h0;
   end

   // one rising scan edge, then drive just after it
   task automatic tick();
      @(posedge i_scan_clk);
      #1;
   endtask

   // shift a whole chain bit 0 first, then pulse apply and await the update
   task automatic load(input logic [143:0] chain, output logic ok);
      int n;
      ok = 1'h1;
      tick();
      o_shift_en = 1'h1;
      tick();
      for (int i = 0; i < 144; i++) begin
         o_scan_data = chain[i];
         tick();
      end
      o_shift_en  = 1'h0;
      o_scan_data = ~o_scan_data;
      o_apply     = 1'h1;
      tick();
      o_apply = 1'h0;
      n = 0;
      while (i_apply_pending !== 1'h1 && n < 4) begin
         tick();
         n++;
      end
      if (i_apply_pending !== 1'h1) ok = 1'h0;
      n = 0;
      while (i_apply_pending !== 1'h0 && n < 16) begin
         tick();
         n++;
      end
      if (i_apply_pending !== 1'h0) ok = 1'h0;
   endtask

   // one phase step; hold keeps the request past completion with direction flipped
   task automatic step(input logic up, input logic [2:0] sel, input logic hold,
                       output int lat, output logic ok);
      int n;
      ok = 1'h1;
      tick();
      o_phase_up   = up;
      o_phase_sel  = sel;
      o_phase_step = 1'h1;
      lat = 0;
      while (i_phase_done !== 1'h0 && lat < 12) begin
         tick();
         lat++;
      end
      if (hold) o_phase_up = ~up;
      else o_phase_step = 1'h0;
      n = 0;
      while (i_phase_done !== 1'h1 && n < 12) begin
         tick();
         n++;
      end
      if (i_phase_done !== 1'h1 || lat >= 12) ok = 1'h0;
      if (hold) repeat (4) tick();
      o_phase_step = 1'h0;
      tick();
   endtask
endmodule

//--- sim/pll_scan_chain_phase_step_tb.sv
`timescale 1ns/1ps
`include "pll_scan_regs.svh"

module pll_scan_chain_phase_step_tb;
   // one chain load: chosen divider fields, bandwidth codes, expected refusal
   typedef struct packed {
      logic [2:0] dv;
      logic [7:0] hi;
      logic [7:0] lo;
      logic       odd;
      logic       byp;
      logic [2:0] pump;
      logic [4:0] res;
      logic [1:0] cap;
      logic       rej;
   } row_t;

   logic        i_mclk     = 1'h0;
   logic        i_reset    = 1'h1;
   logic        i_scan_clk = 1'h0;
   logic        shift_en, scan_data, apply_pulse, apply_pending;
   logic        phase_step, phase_up, phase_done, bw_reject, ok;
   logic [2:0]  phase_sel, pump;
   logic [4:0]  res;
   logic [1:0]  cap;
   logic [62:0] div_ratio;
   logic [6:0]  div_bypass, div_odd;
   logic [17:0] taps, exp_taps;
   logic [9:0]  last_bw;
   int          n_mismatch, comparisons, lat;
   row_t        rows [14] = '{
      '{3'h0, 8'h05, 8'h05, 1'h0, 1'h0, 3'h0, 5'h00, 2'h0, 1'h0},
      '{3'h4, 8'h02, 8'h01, 1'h1, 1'h0, 3'h4, 5'h03, 2'h1, 1'h0},
      '{3'h5, 8'h07, 8'h09, 1'h0, 1'h1, 3'h6, 5'h04, 2'h3, 1'h0},
      '{3'h6, 8'hFF, 8'h01, 1'h1, 1'h0, 3'h7, 5'h08, 2'h0, 1'h0},
      '{3'h1, 8'h80, 8'h80, 1'h0, 1'h0, 3'h0, 5'h10, 2'h1, 1'h0},
      '{3'h2, 8'h01, 8'h00, 1'h0, 1'h1, 3'h4, 5'h13, 2'h3, 1'h0},
      '{3'h3, 8'h03, 8'h04, 1'h1, 1'h0, 3'h6, 5'h14, 2'h0, 1'h0},
      '{3'h0, 8'h10, 8'h01, 1'h0, 1'h0, 3'h7, 5'h18, 2'h1, 1'h0},
      '{3'h4, 8'h00, 8'h02, 1'h0, 1'h0, 3'h0, 5'h1B, 2'h3, 1'h0},
      '{3'h5, 8'h04, 8'h04, 1'h0, 1'h0, 3'h4, 5'h1C, 2'h0, 1'h0},
      '{3'h6, 8'h02, 8'h03, 1'h1, 1'h0, 3'h6, 5'h1E, 2'h1, 1'h0},
      '{3'h1, 8'h06, 8'h06, 1'h0, 1'h0, 3'h2, 5'h00, 2'h0, 1'h1},
      '{3'h2, 8'h02, 8'h02, 1'h0, 1'h0, 3'h7, 5'h05, 2'h0, 1'h1},
      '{3'h3, 8'h09, 8'h01, 1'h0, 1'h0, 3'h0, 5'h00, 2'h2, 1'h1}};

   // core clock and unrelated scan clock
   always #20 i_mclk = ~i_mclk;
   initial begin
      #13;
      forever #40 i_scan_clk = ~i_scan_clk;
   end

   pll_scan_reconfig dut (
      .i_mclk                  (i_mclk),
      .i_reset                 (i_reset),
      .i_scan_clk              (i_scan_clk),
      .i_shift_en              (shift_en),
      .i_scan_data             (scan_data),
      .i_apply                 (apply_pulse),
      .o_apply_pending         (apply_pending),
      .i_phase_step            (phase_step),
      .i_phase_up              (phase_up),
      .i_phase_sel             (phase_sel),
      .o_phase_done            (phase_done),
      .o_div_ratio             (div_ratio),
      .o_div_bypass            (div_bypass),
      .o_div_odd_duty          (div_odd),
      .o_phase_taps            (taps),
      .o_pump_current_code     (pump),
      .o_filter_resistor_code  (res),
      .o_filter_capacitor_code (cap),
      .o_bw_reject             (bw_reject)
   );

   fabric_model far (
      .i_scan_clk      (i_scan_clk),
      .i_phase_done    (phase_done),
      .i_apply_pending (apply_pending),
      .o_shift_en      (shift_en),
      .o_scan_data     (scan_data),
      .o_apply         (apply_pulse),
      .o_phase_step    (phase_step),
      .o_phase_up      (phase_up),
      .o_phase_sel     (phase_sel)
   );

   // verdict and end of run
   task automatic finish_test();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end
      else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // a bounded wait that ran out ends the run
   task automatic need_ok();
      if (ok !== 1'h1) begin
         n_mismatch++;
         finish_test();
      end
   endtask

   task automatic mwait(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   // chain image: chosen divider from the row, the others from their index
   function automatic logic [143:0] make_chain(input row_t r);
      logic [143:0] c;
      int           o;
      c = '0;
      for (int d = 0; d < 7; d++) begin
         o = (d < 5) ? (4 - d) * 18 : 90 + (d - 5) * 18;
         if (d == r.dv) c[o +: 18] = {r.byp, r.odd, r.hi, r.lo};
         else c[o +: 18] = {1'h0, d[0], 8'(d + 1), 8'h02};
      end
      c[126 +: 3] = r.pump;
      c[135 +: 5] = r.res;
      c[140 +: 2] = r.cap;
      return c;
   endfunction

   task automatic check_reset();
      chk_vec(phase_done, 1'h1);
      chk_vec(apply_pending, 1'h0);
      chk_vec(div_ratio, {7{9'h001}});
      chk_vec(div_bypass, 7'h7F);
      chk_vec({div_odd, taps, pump, res, cap, bw_reject}, '0);
   endtask

   task automatic check_row(input row_t r);
      logic [62:0] er;
      logic [6:0]  eb;
      logic [6:0]  eo;
      for (int d = 0; d < 7; d++) begin
         eb[d] = (d == r.dv) ? r.byp : 1'h0;
         eo[d] = (d == r.dv) ? r.odd : d[0];
         if (d == r.dv) er[9*d +: 9] = r.byp ? 9'h001 : r.hi + r.lo;
         else er[9*d +: 9] = 9'(d + 1) + 9'h002;
      end
      if (!r.rej) last_bw = {r.pump, r.res, r.cap};
      chk_vec(div_ratio, er);
      chk_vec(div_bypass, eb);
      chk_vec(div_odd, eo);
      chk_vec({pump, res, cap}, last_bw);
      chk_vec(bw_reject, r.rej);
   endtask

   // one step, its latency, then the expected tap move
   task automatic do_step(input logic u, input logic [2:0] s, input logic hold);
      far.step(u, s, hold, lat, ok);
      need_ok();
      chk_cnt(lat, 2);
      mwait(3);
      for (int i = 0; i < 6; i++) begin
         if ((s == 3'h0 && i < 5) || (s == 3'h1 && i == 5) ||
             (s >= 3'h2 && s <= 3'h6 && i == s - 2)) begin
            exp_taps[3*i +: 3] = exp_taps[3*i +: 3] + (u ? 3'h1 : 3'h7);
         end
      end
      chk_vec(taps, exp_taps);
   endtask

   // main sequence
   initial begin
      n_mismatch  = 0;
      comparisons = 0;
      exp_taps    = '0;
      last_bw     = '0;
      repeat (8) @(posedge i_mclk);
      #1;
      i_reset = 1'h0;
      check_reset();
      repeat (4) @(posedge i_scan_clk);
      foreach (rows[k]) begin
         far.load(make_chain(rows[k]), ok);
         need_ok();
         mwait(3);
         check_row(rows[k]);
      end
      // every select, down first so the taps wrap
      for (int u = 0; u < 2; u++) begin
         for (int s = 0; s < 8; s++) begin
            do_step(u[0], s[2:0], 1'h0);
         end
      end
      // request held past completion, direction flipped after capture
      do_step(1'h1, 3'h4, 1'h1);
      // reset in mid-run
      i_reset = 1'h1;
      mwait(8);
      i_reset = 1'h0;
      check_reset();
      finish_test();
   end
endmodule
